// ### include/uhp_pkg.sv
// Purpose: Shared constants and types for the upper address port block.
// Assumes: Avalon-MM register bus with byte addresses, 32-bit data words.
// Notes: Each port register holds eight bits in the low byte of its word.
`default_nettype none
package uhp_pkg;
   // Pin counts of the two product variants
   localparam int unsigned UHP_NPIN_WIDE = 8;
   localparam int unsigned UHP_NPIN_NARROW = 6;
   localparam logic [7:0] UHP_MASK_WIDE = 8'hFF;
   localparam logic [7:0] UHP_MASK_NARROW = 8'h3F;
   // Lowest external address line carried by pin 0
   localparam int unsigned UHP_EXT_ADDR_BASE = 16;

   // Register byte offsets
   localparam int unsigned UHP_ADDR_W = 6;
   localparam logic [5:0] UHP_OFS_DATA = 6'h00;
   localparam logic [5:0] UHP_OFS_DIR = 6'h04;
   localparam logic [5:0] UHP_OFS_FUNC = 6'h08;
   localparam logic [5:0] UHP_OFS_DATA_SET = 6'h0C;
   localparam logic [5:0] UHP_OFS_DATA_CLR = 6'h10;
   localparam logic [5:0] UHP_OFS_DIR_SET = 6'h14;
   localparam logic [5:0] UHP_OFS_DIR_CLR = 6'h18;
   localparam logic [5:0] UHP_OFS_FUNC_SET = 6'h1C;
   localparam logic [5:0] UHP_OFS_FUNC_CLR = 6'h20;
   localparam logic [5:0] UHP_OFS_PINS = 6'h24;
   localparam logic [5:0] UHP_OFS_STAT = 6'h28;
   localparam logic [5:0] UHP_OFS_CFG = 6'h2C;

   // Reset values
   localparam logic [7:0] UHP_RST_DATA = 8'h00;
   localparam logic [7:0] UHP_RST_DIR = 8'hFF;
   localparam logic [7:0] UHP_RST_FUNC = 8'h00;

   // Status and configuration fields
   localparam int unsigned UHP_STAT_UNUSED_POS = 0;
   localparam int unsigned UHP_CFG_NPIN_LSB = 0;
   localparam int unsigned UHP_CFG_NPIN_W = 4;

   // Avalon response codes
   localparam logic [1:0] UHP_RESP_OKAY = 2'h0;
   localparam logic [1:0] UHP_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      UHP_OP_NONE,
      UHP_OP_WRITE,
      UHP_OP_SET,
      UHP_OP_CLR
   } uhp_op_t;

   typedef enum logic [2:0] {
      UHP_SEL_NONE,
      UHP_SEL_DATA,
      UHP_SEL_DIR,
      UHP_SEL_FUNC,
      UHP_SEL_PINS,
      UHP_SEL_STAT,
      UHP_SEL_CFG
   } uhp_sel_t;

   typedef enum logic {
      UHP_BUS_IDLE,
      UHP_BUS_ACK
   } uhp_bus_state_t;
endpackage
`default_nettype wire

// ### hdl/uhp_bitreg.sv
// Purpose: One byte-wide port register with whole-byte, set and clear writes.
// Assumes: At most one of the write strobes is high in a cycle.
// Notes: Bits outside the valid mask always hold zero.
`default_nettype none
module uhp_bitreg #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] VALID_MASK = 8'hFF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Write request
   input wire uhp_pkg::uhp_op_t op,
   input wire logic [7:0] wdata,
   // Stored value
   output logic [7:0] q_r
);
   import uhp_pkg::*;

   logic [7:0] q_nxt;

   always_comb begin
      case (op)
         UHP_OP_WRITE: q_nxt = wdata;
         UHP_OP_SET: q_nxt = q_r | wdata;
         UHP_OP_CLR: q_nxt = q_r & ~wdata;
         default: q_nxt = q_r;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         q_r <= RESET_VAL & VALID_MASK;
      end else begin
         q_r <= q_nxt & VALID_MASK;
      end
   end
endmodule
`default_nettype wire

// ### hdl/uhp_pin_cell.sv
// Purpose: Registered pin drivers choosing between port latch and address line.
// Assumes: All inputs are in the core_clk domain.
// Notes: Pins outside the valid mask are never driven.
`default_nettype none
module uhp_pin_cell #(
   parameter logic [7:0] VALID_MASK = 8'hFF
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Configuration
   input wire logic [7:0] latch,
   input wire logic [7:0] dir,
   input wire logic [7:0] func,
   // External address lines 16 upward
   input wire logic [7:0] ext_addr_hi,
   // Pin drive
   output logic [7:0] pin_out_r,
   output logic [7:0] pin_oe_r
);
   logic [7:0] out_nxt;
   logic [7:0] oe_nxt;

   always_comb begin
      // [RULE8] Address line select
      out_nxt = (func & ext_addr_hi) | (~func & latch);
      // [RULE5] Output when clear
      oe_nxt = (func | ~dir) & VALID_MASK;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pin_out_r <= 8'h00;
         pin_oe_r <= 8'h00;
      end else begin
         // [RULE3] Latch drives level
         pin_out_r <= out_nxt & VALID_MASK;
         pin_oe_r <= oe_nxt;
      end
   end
endmodule
`default_nettype wire

// ### hdl/uhp_port.sv
// Purpose: Upper address port, six or eight pins, with three port registers.
// Assumes: Pin inputs are synchronous to core_clk; Avalon-MM slave access.
// Notes: Set and clear aliases give single-bit writes without read-modify-write.
//
// What this block does
// [RULE1] Each pin is independently an input or an output, one bit each.
// [RULE2] A parameter selects six pins or eight pins.
// [RULE3] Data register reads pins, writes latch; latch 0 drives low, 1 high.
// [RULE4] Data and direction registers take byte writes or single-bit writes.
// [RULE5] Direction bit 0 makes the pin output, 1 makes it input.
// [RULE6] Function bit 0 keeps port I/O, 1 gives pin to address bus.
// [RULE7] Function register takes byte writes or single-bit writes.
// [RULE8] Selected pin n drives external address bit 16 plus n.
// [RULE9] Software gives input or output data per bit via data register.
// [RULE10] Reads show pin level for inputs, latch for outputs; latch drives outputs.
// [RULE11] On the narrow part software writes zero to bits 6 and 7.
`default_nettype none
module uhp_port #(
   parameter bit WIDE_VARIANT = 1'b1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Avalon-MM register slave
   input wire logic [uhp_pkg::UHP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic [1:0] avs_response,
   output logic avs_waitrequest,
   // External memory address lines 16 to 23
   input wire logic [7:0] ext_addr_hi,
   // Pins
   input wire logic [7:0] port_pin_in,
   output logic [7:0] port_pin_out,
   output logic [7:0] port_pin_oe,
   // Status
   output logic unused_bit_written
);
   import uhp_pkg::*;

   // [RULE2] Variant width
   localparam logic [7:0] VALID_MASK = WIDE_VARIANT ? UHP_MASK_WIDE : UHP_MASK_NARROW;
   localparam int unsigned NPIN = WIDE_VARIANT ? UHP_NPIN_WIDE : UHP_NPIN_NARROW;
   localparam logic [UHP_CFG_NPIN_W-1:0] NPIN_CODE = UHP_CFG_NPIN_W'(NPIN);

   // Address decode shared by reads and writes
   function automatic uhp_sel_t uhp_decode(input logic [UHP_ADDR_W-1:0] a);
      case (a)
         UHP_OFS_DATA, UHP_OFS_DATA_SET, UHP_OFS_DATA_CLR: uhp_decode = UHP_SEL_DATA;
         UHP_OFS_DIR, UHP_OFS_DIR_SET, UHP_OFS_DIR_CLR: uhp_decode = UHP_SEL_DIR;
         UHP_OFS_FUNC, UHP_OFS_FUNC_SET, UHP_OFS_FUNC_CLR: uhp_decode = UHP_SEL_FUNC;
         UHP_OFS_PINS: uhp_decode = UHP_SEL_PINS;
         UHP_OFS_STAT: uhp_decode = UHP_SEL_STAT;
         UHP_OFS_CFG: uhp_decode = UHP_SEL_CFG;
         default: uhp_decode = UHP_SEL_NONE;
      endcase
   endfunction

   // Kind of write an offset performs
   function automatic uhp_op_t uhp_write_kind(input logic [UHP_ADDR_W-1:0] a);
      case (a)
         UHP_OFS_DATA, UHP_OFS_DIR, UHP_OFS_FUNC: uhp_write_kind = UHP_OP_WRITE;
         UHP_OFS_DATA_SET, UHP_OFS_DIR_SET, UHP_OFS_FUNC_SET: uhp_write_kind = UHP_OP_SET;
         UHP_OFS_DATA_CLR, UHP_OFS_DIR_CLR, UHP_OFS_FUNC_CLR: uhp_write_kind = UHP_OP_CLR;
         default: uhp_write_kind = UHP_OP_NONE;
      endcase
   endfunction

   // Bus handshake state
   uhp_bus_state_t bus_state_r;
   uhp_bus_state_t bus_state_nxt;
   logic waitrequest_r;
   logic [31:0] readdata_r;
   logic [31:0] readdata_nxt;
   logic [1:0] response_r;
   logic [1:0] response_nxt;

   // Decoded request
   uhp_sel_t sel;
   uhp_op_t kind;
   logic wr_fire;
   logic byte0_en;
   logic [7:0] wbyte;

   // Register strobes
   uhp_op_t data_op;
   uhp_op_t dir_op;
   uhp_op_t func_op;
   logic stat_clear;

   // Register contents
   logic [7:0] data_latch;
   logic [7:0] dir_bits;
   logic [7:0] func_bits;
   logic [7:0] data_view;
   logic unused_flag_r;
   logic unused_hit;

   assign sel = uhp_decode(avs_address);
   assign kind = uhp_write_kind(avs_address);
   assign byte0_en = avs_byteenable[0];
   assign wbyte = avs_writedata[7:0];

   // Write lands at the edge where waitrequest is sampled low
   assign wr_fire = avs_write && (bus_state_r == UHP_BUS_ACK);

   always_comb begin
      bus_state_nxt = bus_state_r;
      case (bus_state_r)
         UHP_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               bus_state_nxt = UHP_BUS_ACK;
            end
         end
         UHP_BUS_ACK: bus_state_nxt = UHP_BUS_IDLE;
         default: bus_state_nxt = UHP_BUS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         bus_state_r <= UHP_BUS_IDLE;
      end else begin
         bus_state_r <= bus_state_nxt;
      end
   end

   // Waitrequest drops for exactly the acknowledge cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         waitrequest_r <= 1'b1;
      end else begin
         waitrequest_r <= (bus_state_nxt != UHP_BUS_ACK);
      end
   end

   // Write strobes for the three port registers
   always_comb begin
      data_op = UHP_OP_NONE;
      dir_op = UHP_OP_NONE;
      func_op = UHP_OP_NONE;
      stat_clear = 1'b0;
      if (wr_fire && byte0_en) begin
         case (sel)
            // [RULE4] Byte or bit write
            UHP_SEL_DATA: data_op = kind;
            UHP_SEL_DIR: dir_op = kind;
            // [RULE7] Byte or bit write
            UHP_SEL_FUNC: func_op = kind;
            UHP_SEL_STAT: stat_clear = wbyte[UHP_STAT_UNUSED_POS];
            default: begin
               data_op = UHP_OP_NONE;
            end
         endcase
      end
   end

   // [RULE9] Per-bit data latch
   uhp_bitreg #(
      .RESET_VAL(UHP_RST_DATA),
      .VALID_MASK(VALID_MASK)
   ) u_data (
      .core_clk(core_clk),
      .srst(srst),
      .op(data_op),
      .wdata(wbyte),
      .q_r(data_latch)
   );

   // [RULE1] Per-bit direction
   uhp_bitreg #(
      .RESET_VAL(UHP_RST_DIR),
      .VALID_MASK(VALID_MASK)
   ) u_dir (
      .core_clk(core_clk),
      .srst(srst),
      .op(dir_op),
      .wdata(wbyte),
      .q_r(dir_bits)
   );

   // [RULE6] Per-bit function select
   uhp_bitreg #(
      .RESET_VAL(UHP_RST_FUNC),
      .VALID_MASK(VALID_MASK)
   ) u_func (
      .core_clk(core_clk),
      .srst(srst),
      .op(func_op),
      .wdata(wbyte),
      .q_r(func_bits)
   );

   // [RULE11] Writes of ones to absent bits are flagged
   assign unused_hit = wr_fire && byte0_en && (sel == UHP_SEL_DATA || sel == UHP_SEL_DIR
      || sel == UHP_SEL_FUNC) && ((wbyte & ~VALID_MASK) != 8'h00);

   // Sticky flag; a new hit wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         unused_flag_r <= 1'b0;
      end else if (unused_hit) begin
         unused_flag_r <= 1'b1;
      end else if (stat_clear) begin
         unused_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         unused_bit_written <= 1'b0;
      end else begin
         unused_bit_written <= unused_flag_r;
      end
   end

   // [RULE10] Inputs read the pin, outputs read the latch
   assign data_view = ((dir_bits & port_pin_in) | (~dir_bits & data_latch)) & VALID_MASK;

   // Read data and response, captured at the edge that first sees the request in idle
   always_comb begin
      readdata_nxt = 32'h0000_0000;
      response_nxt = UHP_RESP_OKAY;
      case (sel)
         // [RULE3] Pin state on read
         UHP_SEL_DATA: readdata_nxt[7:0] = data_view;
         UHP_SEL_DIR: readdata_nxt[7:0] = dir_bits;
         UHP_SEL_FUNC: readdata_nxt[7:0] = func_bits;
         UHP_SEL_PINS: readdata_nxt[7:0] = port_pin_in & VALID_MASK;
         UHP_SEL_STAT: readdata_nxt[UHP_STAT_UNUSED_POS] = unused_flag_r;
         UHP_SEL_CFG: begin
            readdata_nxt[UHP_CFG_NPIN_LSB +: UHP_CFG_NPIN_W] = NPIN_CODE;
         end
         default: response_nxt = UHP_RESP_SLVERR;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         readdata_r <= 32'h0000_0000;
      end else if (bus_state_r == UHP_BUS_IDLE && avs_read) begin
         readdata_r <= readdata_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         response_r <= UHP_RESP_OKAY;
      end else if (bus_state_r == UHP_BUS_IDLE && (avs_read || avs_write)) begin
         response_r <= response_nxt;
      end
   end

   assign avs_waitrequest = waitrequest_r;
   assign avs_readdata = readdata_r;
   assign avs_response = response_r;

   // [RULE8] Pin drive from latch or address
   uhp_pin_cell #(
      .VALID_MASK(VALID_MASK)
   ) u_pins (
      .core_clk(core_clk),
      .srst(srst),
      .latch(data_latch),
      .dir(dir_bits),
      .func(func_bits),
      .ext_addr_hi(ext_addr_hi),
      .pin_out_r(port_pin_out),
      .pin_oe_r(port_pin_oe)
   );
endmodule
`default_nettype wire

// ### test/uhp_port_chk.sv
// Purpose: Bus and pin timing checks for the upper address port.
// Assumes: Bound to every uhp_port instance; requests use aligned offsets.
// Notes: Shadows the three port registers from the bus writes it observes.
`default_nettype none
module uhp_port_chk #(
   parameter bit WIDE_VARIANT = 1'b1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Register bus
   input wire logic [uhp_pkg::UHP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic [1:0] avs_response,
   input wire logic avs_waitrequest,
   // Address lines and pins
   input wire logic [7:0] ext_addr_hi,
   input wire logic [7:0] port_pin_in,
   input wire logic [7:0] port_pin_out,
   input wire logic [7:0] port_pin_oe,
   input wire logic unused_bit_written
);
   timeunit 1ns;
   timeprecision 1ps;
   import uhp_pkg::*;
   localparam logic [7:0] MSK = WIDE_VARIANT ? UHP_MASK_WIDE : UHP_MASK_NARROW;
   logic [7:0] d_r, m_r, f_r, wd;
   assign wd = avs_writedata[7:0] & MSK;

   // Next value of one shadow register for the write now completing
   function automatic logic [7:0] upd(logic [7:0] v, logic [5:0] w, s, c);
      if (avs_address == w) return wd;
      if (avs_address == s) return v | wd;
      if (avs_address == c) return v & ~wd;
      return v;
   endfunction

   always_ff @(posedge core_clk) begin
      if (srst) begin
         d_r <= UHP_RST_DATA;
         m_r <= UHP_RST_DIR & MSK;
         f_r <= UHP_RST_FUNC;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
         d_r <= upd(d_r, UHP_OFS_DATA, UHP_OFS_DATA_SET, UHP_OFS_DATA_CLR);
         m_r <= upd(m_r, UHP_OFS_DIR, UHP_OFS_DIR_SET, UHP_OFS_DIR_CLR);
         f_r <= upd(f_r, UHP_OFS_FUNC, UHP_OFS_FUNC_SET, UHP_OFS_FUNC_CLR);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   wait_ack_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
      else $error("request not acknowledged");
   ack_single_a: assert property (
      !avs_waitrequest |=> avs_waitrequest) else $error("ack longer than one cycle");
   reset_quiet_a: assert property (
      $fell(srst) |-> avs_waitrequest && port_pin_oe == 8'h00 && !unused_bit_written)
      else $error("outputs not quiet after reset");
   narrow_pins_a: assert property (
      (port_pin_oe & ~MSK) == 8'h00) else $error("absent pin driven");
   oe_map_a: assert property (
      port_pin_oe == $past((f_r | ~m_r) & MSK)) else $error("pin enable wrong");
   out_map_a: assert property (
      (port_pin_out & MSK) == $past((f_r & ext_addr_hi | ~f_r & d_r) & MSK))
      else $error("pin level wrong");
   data_read_a: assert property (
      !avs_waitrequest && $past(avs_read && avs_address == UHP_OFS_DATA) |->
      avs_readdata == {24'h0, $past((m_r & port_pin_in | ~m_r & d_r) & MSK)})
      else $error("data read wrong");
   func_read_a: assert property (
      !avs_waitrequest && $past(avs_read && avs_address == UHP_OFS_FUNC) |->
      avs_readdata[7:0] == $past(f_r)) else $error("function read wrong");
   resp_code_a: assert property (
      !avs_waitrequest |->
      avs_response == ($past(avs_address) > UHP_OFS_CFG ? UHP_RESP_SLVERR : UHP_RESP_OKAY))
      else $error("response code wrong");
endmodule

bind uhp_port uhp_port_chk #(.WIDE_VARIANT(WIDE_VARIANT)) chk (.core_clk(core_clk),
   .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_response(avs_response),
   .avs_waitrequest(avs_waitrequest), .ext_addr_hi(ext_addr_hi), .port_pin_in(port_pin_in),
   .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
   .unused_bit_written(unused_bit_written));
`default_nettype wire

// ### test/uhp_pin_model.sv
// Purpose: External pins and high address bus facing the upper address port.
// Assumes: No pull resistors; an outside driver always holds each pin.
// Notes: Where the port drives a pin, the pin shows the port's level.
`default_nettype none
module uhp_pin_model (
   // Port side
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // Outside world
   input wire logic [7:0] ext_level,
   input wire logic [7:0] addr_hi,
   output logic [7:0] pin_level,
   output logic [7:0] ext_addr_hi
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
   assign ext_addr_hi = addr_hi;
endmodule
`default_nettype wire

// ### test/tb_uhp_port.sv
// Purpose: Self-checking bench for the upper address port, both variants.
// Assumes: One bus master drives the wide and narrow instances in lockstep.
// Notes: Expected values are worked out by hand from the register writes.
`default_nettype none
module tb_uhp_port;
   timeunit 1ns;
   timeprecision 1ps;
   import uhp_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [7:0] ext_lvl = 8'h00;
   logic [7:0] addr_hi = 8'h00;
   logic [31:0] rd_w, rd_n;
   logic [1:0] rsp, rsp_n;
   wire [31:0] rdata [2];
   wire [1:0] resp [2];
   wire [7:0] pin_in [2], pout [2], poe [2], ext_a [2];
   wire wrq [2], ubw [2];
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;

   // Index 0 is the eight-pin part, index 1 the six-pin part
   for (genvar i = 0; i < 2; i++) begin : g_dut
      uhp_port #(.WIDE_VARIANT(1'(i == 0))) uut (.core_clk(core_clk), .srst(srst),
         .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
         .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
         .avs_readdata(rdata[i]), .avs_response(resp[i]), .avs_waitrequest(wrq[i]),
         .ext_addr_hi(ext_a[i]), .port_pin_in(pin_in[i]), .port_pin_out(pout[i]),
         .port_pin_oe(poe[i]), .unused_bit_written(ubw[i]));
      uhp_pin_model pins (.pin_out(pout[i]), .pin_oe(poe[i]), .ext_level(ext_lvl),
         .addr_hi(addr_hi), .pin_level(pin_in[i]), .ext_addr_hi(ext_a[i]));
   end

   always #4 core_clk = ~core_clk;

   task automatic stop_test();
      if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One access, held until waitrequest is sampled low, then an idle cycle
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'h1);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      do @(posedge core_clk); while (wrq[0] !== 1'b0);
      rd_w = rdata[0];
      rd_n = rdata[1];
      rsp = resp[0];
      rsp_n = resp[1];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rchk(input logic [5:0] a, input logic [7:0] ew, input logic [7:0] en);
      bus(1'b0, a, 8'h00);
      check("read wide", rd_w, {24'h0, ew});
      check("read narrow", rd_n, {24'h0, en});
   endtask

   task automatic pchk(input logic [7:0] oe_w, out_w, oe_n, out_n);
      check("oe wide", {24'h0, poe[0]}, {24'h0, oe_w});
      check("out wide", {24'h0, pout[0]}, {24'h0, out_w});
      check("oe narrow", {24'h0, poe[1]}, {24'h0, oe_n});
      check("out narrow", {24'h0, pout[1] & 8'h3F}, {24'h0, out_n});
   endtask

   initial begin
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      ext_lvl <= 8'hA5;
      rchk(UHP_OFS_DIR, 8'hFF, 8'h3F);
      rchk(UHP_OFS_FUNC, 8'h00, 8'h00);
      rchk(UHP_OFS_DATA, 8'hA5, 8'h25);
      rchk(UHP_OFS_CFG, 8'h08, 8'h06);
      ext_lvl <= 8'h5A;
      bus(1'b1, UHP_OFS_DATA, 8'h3C);
      bus(1'b1, UHP_OFS_DIR, 8'h0F);
      rchk(UHP_OFS_DATA, 8'h3A, 8'h3A);
      pchk(8'hF0, 8'h3C, 8'h30, 8'h3C);
      bus(1'b1, UHP_OFS_DIR_CLR, 8'h01);
      bus(1'b1, UHP_OFS_DATA_SET, 8'h41);
      bus(1'b1, UHP_OFS_DATA_CLR, 8'h10);
      rchk(UHP_OFS_DATA, 8'h6B, 8'h2B);
      rchk(UHP_OFS_DIR, 8'h0E, 8'h0E);
      check("flags", {30'h0, ubw[1], ubw[0]}, 32'h2);
      rchk(UHP_OFS_STAT, 8'h00, 8'h01);
      bus(1'b1, UHP_OFS_STAT, 8'h01);
      rchk(UHP_OFS_STAT, 8'h00, 8'h00);
      check("flags clear", {30'h0, ubw[1], ubw[0]}, 32'h0);
      bus(1'b1, UHP_OFS_DIR_SET, 8'h01);
      addr_hi <= 8'hC3;
      bus(1'b1, UHP_OFS_FUNC, 8'hF0);
      bus(1'b1, UHP_OFS_FUNC_SET, 8'h03);
      rchk(UHP_OFS_FUNC, 8'hF3, 8'h33);
      check("flags func", {30'h0, ubw[1], ubw[0]}, 32'h2);
      pchk(8'hF3, 8'hCF, 8'h33, 8'h0F);
      bus(1'b1, UHP_OFS_FUNC_CLR, 8'hF0);
      addr_hi <= 8'h3C;
      rchk(UHP_OFS_FUNC, 8'h03, 8'h03);
      pchk(8'hF3, 8'h6C, 8'h33, 8'h2C);
      bus(1'b1, UHP_OFS_DATA, 8'hFF, 4'h0);
      rchk(UHP_OFS_DATA, 8'h68, 8'h28);
      rchk(UHP_OFS_PINS, 8'h68, 8'h28);
      check("resp ok", {28'h0, rsp_n, rsp},
         {28'h0, UHP_RESP_OKAY, UHP_RESP_OKAY});
      bus(1'b1, UHP_OFS_CFG, 8'hFF);
      check("resp cfg", {28'h0, rsp_n, rsp},
         {28'h0, UHP_RESP_OKAY, UHP_RESP_OKAY});
      rchk(UHP_OFS_CFG, 8'h08, 8'h06);
      rchk(6'h30, 8'h00, 8'h00);
      check("resp rd", {28'h0, rsp_n, rsp},
         {28'h0, UHP_RESP_SLVERR, UHP_RESP_SLVERR});
      bus(1'b1, 6'h34, 8'h55);
      check("resp wr", {28'h0, rsp_n, rsp},
         {28'h0, UHP_RESP_SLVERR, UHP_RESP_SLVERR});
      stop_test();
   end
endmodule
`default_nettype wire
